// ### inc/csf_pkg.sv
package csf_pkg;
  // wishbone word offsets (byte addresses)
  localparam logic [7:0] OFS_PORT_MODE = 8'h00;
  localparam logic [7:0] OFS_RATE_CTRL = 8'h04;
  localparam logic [7:0] OFS_REF_CTRL = 8'h08;
  localparam logic [7:0] OFS_GAIN_CTRL = 8'h0c;
  localparam logic [7:0] OFS_DAC_CTRL = 8'h10;
  localparam logic [7:0] OFS_ADC_STAT = 8'h14;
  localparam logic [7:0] OFS_WORD_STAT = 8'h18;
  // field positions
  localparam int POS_MODE_DATA = 0;
  localparam int POS_MODE_MIXED = 1;
  localparam int POS_RATE_SEL = 0;
  localparam int POS_MCLK_DIV = 4;
  localparam int POS_REF_UP = 6;
  localparam int POS_GAIN_SEL = 4;
  localparam int POS_MUTE = 7;
  localparam int POS_IBYPASS = 5;
  // values after reset
  localparam logic [1:0] RST_MODE = 2'h0;
  localparam logic [1:0] RST_RATE_SEL = 2'h0;
  localparam logic [2:0] RST_MCLK_DIV = 3'h0;
  localparam logic [2:0] RST_GAIN_SEL = 3'h0;
  localparam logic [15:0] RST_DAC_WORD = 16'h0000;
  // cycle counts
  localparam logic [2:0] MOD_DIV_LAST = 3'h7;  // device clock over 8
  localparam logic [1:0] SCLK_HALF_LAST = 2'h3; // 4 device clocks per half
  localparam logic [4:0] SP_BITS_LAST = 5'h0f;  // 16-bit frame
  // datapath widths and limits
  localparam int DEC_W = 27;
  localparam int INT_W = 40;
  localparam int DSM_W = 18;
  localparam int DEC_OUT_SHIFT = 14;
  localparam logic [14:0] ADC_POS_MAX = 15'h3fff;
  localparam logic [14:0] ADC_NEG_MAX = 15'h4000;
  localparam logic [15:0] DAC_POS_FS = 16'h7fff;
  localparam logic [15:0] DAC_NEG_FS = 16'h8000;
  localparam logic FLAG_DATA = 1'b0;

  // log2 of the moving-sum length for a rate code: 256,128,64,32
  function automatic logic [3:0] csf_log2n(input logic [1:0] rate);
    csf_log2n = 4'h8 - {2'h0, rate};
  endfunction

  // last count of a sample interval in modulator ticks (length minus one)
  function automatic logic [7:0] csf_len_last(input logic [1:0] rate);
    csf_len_last = 8'hff >> rate;
  endfunction
endpackage

// ### src/csf_decim.sv
`timescale 1ns/1ps
`default_nettype none
module csf_decim (
  input wire logic clk_i,                  // master clock
  input wire logic rst_i,                  // sync reset, active high
  input wire logic ce_i,                   // modulator rate tick
  input wire logic smp_i,                  // sample strobe, on a ce_i cycle
  input wire logic bit_i,                  // modulator bit, 1 means +1
  input wire logic [1:0] rate_i,           // sample rate code
  output logic [14:0] word_o               // decimated sample
);
  import csf_pkg::*;

  logic signed [DEC_W-1:0] in1_r, in2_r, in3_r;
  logic signed [DEC_W-1:0] cd1_r, cd2_r, cd3_r;
  logic signed [DEC_W-1:0] x_in, d1, d2, d3, scaled;
  logic [3:0] shamt;

  // single bit maps onto +1 or -1
  assign x_in = bit_i ? DEC_W'(1) : -DEC_W'(1);
  // combs at the low rate; one-sample delay gives the length-n sum
  assign d1 = in3_r - cd1_r;
  assign d2 = d1 - cd2_r;
  assign d3 = d2 - cd3_r;
  // full scale is n cubed, bring it to 15 bits
  assign shamt = 4'(3 * csf_log2n(rate_i) - DEC_OUT_SHIFT);
  assign scaled = d3 >>> shamt;

  // three integrators at the modulator rate
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      in1_r <= '0;
      in2_r <= '0;
      in3_r <= '0;
    end
    else if (ce_i)
    begin
      in1_r <= in1_r + x_in;
      in2_r <= in2_r + in1_r;
      in3_r <= in3_r + in2_r;
    end
  end

  // comb delays and saturated output; +n^3 would overflow by one lsb
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cd1_r <= '0;
      cd2_r <= '0;
      cd3_r <= '0;
      word_o <= '0;
    end
    else if (smp_i)
    begin
      cd1_r <= in3_r;
      cd2_r <= d1;
      cd3_r <= d2;
      if (scaled > DEC_W'(signed'({1'b0, ADC_POS_MAX})))
        word_o <= ADC_POS_MAX;
      else if (scaled < -DEC_W'(signed'({1'b0, ADC_NEG_MAX})))
        word_o <= ADC_NEG_MAX;
      else
        word_o <= scaled[14:0];
    end
  end
endmodule
`default_nettype wire

// ### src/csf_codec_core.sv
// Our own choices: the Wishbone register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module csf_codec_core (
  input wire logic clk_i,                  // external master clock
  input wire logic rst_i,                  // sync reset, active high
  // classic wishbone slave
  input wire logic wb_cyc_i,               // cycle
  input wire logic wb_stb_i,               // strobe
  input wire logic wb_we_i,                // write enable
  input wire logic [7:0] wb_adr_i,         // byte address
  input wire logic [3:0] wb_sel_i,         // byte lanes
  input wire logic [31:0] wb_dat_i,        // write data
  output logic [31:0] wb_dat_o,            // read data
  output logic wb_ack_o,                   // acknowledge
  // converter side
  input wire logic adc_bit_i,              // analog modulator bitstream
  output logic mod_tick_o,                 // modulator rate pulse
  output logic dac_bit_o,                  // digital modulator bit
  output logic [2:0] output_gain_sel_o,    // analog output gain code
  output logic mute_o,                     // analog output mute
  output logic reference_output_enable_o,  // buffered reference enable
  // serial host port
  output logic sclk_o,                     // serial clock
  output logic sdo_o,                      // serial data out
  output logic sdofs_o,                    // output frame sync
  input wire logic sdi_i,                  // serial data in
  input wire logic sdifs_i                 // input frame sync
);
  import csf_pkg::*;

  typedef enum logic [1:0] {SP_IDLE, SP_SYNC, SP_SHIFT} csf_sp_e;

  // control registers
  logic [1:0] mode_r;
  logic [1:0] rate_r;
  logic [2:0] mdiv_r;
  logic ref_up_r;
  logic [2:0] gain_r;
  logic mute_r;
  logic byp_r;
  // clock enables
  logic [2:0] mdiv_cnt_r;
  logic [2:0] mod_cnt_r;
  logic [7:0] smp_cnt_r;
  logic [1:0] half_cnt_r;
  logic [2:0] mdiv_last;
  logic dm_ce, mod_ce, smp, half_ce;
  // synchronisers
  logic adc_s1_r, adc_s2_r, sdi_s1_r, sdi_s2_r, fs_s1_r, fs_s2_r;
  // serial port
  csf_sp_e sp_st_r;
  logic [15:0] shreg_r;
  logic [15:0] shift_nxt;
  logic [4:0] bit_cnt_r;
  logic pend_r, rx_en_r, sclk_r, rise_ev, fall_ev, frame_end;
  logic mixed, is_ctrl;
  logic [15:0] tx_word, rx_dac;
  // sample words
  logic [14:0] adc_word;
  logic [15:0] dac_hold_r;
  logic [15:0] dac_cur_r;
  logic [15:0] ctl_word_r;
  // interpolator
  logic signed [INT_W-1:0] ci_d1_r, ci_d2_r, ci_d3_r, comb_r;
  logic signed [INT_W-1:0] e1, e2, e3, ip_in, ip_scaled;
  logic signed [INT_W-1:0] ig1_r, ig2_r, ig3_r;
  logic stuff_r;
  logic [15:0] ip_out, dsm_in;
  // sigma-delta modulator
  logic signed [DSM_W-1:0] dsm_acc_r, dsm_fb;
  // bus
  logic wb_req, wb_wr, lane0;
  logic hit_mode, hit_rate, hit_ref, hit_gain, hit_dac, hit_adc, hit_word;
  logic [31:0] rd_mux;

  // divide ratios 1..5, unused codes fall back to 1
  assign mdiv_last = (mdiv_r > 3'h4) ? 3'h0 : mdiv_r;
  assign dm_ce = (mdiv_cnt_r == mdiv_last);
  assign mod_ce = dm_ce && (mod_cnt_r == MOD_DIV_LAST);
  assign smp = mod_ce && (smp_cnt_r == csf_len_last(rate_r));
  assign half_ce = dm_ce && (half_cnt_r == SCLK_HALF_LAST);

  // clock dividers; every slower rate is an enable off the master clock
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      mdiv_cnt_r <= '0;
      mod_cnt_r <= '0;
      smp_cnt_r <= '0;
      half_cnt_r <= '0;
    end
    else
    begin
      mdiv_cnt_r <= dm_ce ? 3'h0 : mdiv_cnt_r + 3'h1;
      if (dm_ce)
      begin
        mod_cnt_r <= mod_cnt_r + 3'h1;
        half_cnt_r <= half_cnt_r + 2'h1;
      end
      // rate change restarts cleanly since a count past the new last one is cleared
      if (smp || (mod_ce && smp_cnt_r > csf_len_last(rate_r)))
        smp_cnt_r <= '0;
      else if (mod_ce)
        smp_cnt_r <= smp_cnt_r + 8'h1;
    end
  end

  // pin inputs come from other clock domains: two flops each
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      {adc_s1_r, adc_s2_r} <= 2'h0;
      {sdi_s1_r, sdi_s2_r} <= 2'h0;
      {fs_s1_r, fs_s2_r} <= 2'h0;
    end
    else
    begin
      adc_s1_r <= adc_bit_i;
      adc_s2_r <= adc_s1_r;
      sdi_s1_r <= sdi_i;
      sdi_s2_r <= sdi_s1_r;
      fs_s1_r <= sdifs_i;
      fs_s2_r <= fs_s1_r;
    end
  end

  // adc decimation
  csf_decim u_decim (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(mod_ce),
    .smp_i(smp),
    .bit_i(adc_s2_r),
    .rate_i(rate_r),
    .word_o(adc_word)
  );

  // serial framing decode
  assign mixed = mode_r[POS_MODE_DATA] && mode_r[POS_MODE_MIXED];
  assign rise_ev = half_ce && !sclk_r;
  assign fall_ev = half_ce && sclk_r;
  assign shift_nxt = {shreg_r[14:0], sdi_s2_r};
  assign frame_end = fall_ev && (sp_st_r == SP_SHIFT)
    && (bit_cnt_r == SP_BITS_LAST);
  // data flag in the msb for mixed mode, else sample left justified
  assign tx_word = mixed ? {FLAG_DATA, adc_word} : {adc_word, 1'b0};
  // control mode carries control only; mixed mode flags it in the msb
  assign is_ctrl = !mode_r[POS_MODE_DATA]
    || (mixed && (shift_nxt[15] != FLAG_DATA));
  assign rx_dac = mixed ? {shift_nxt[14:0], 1'b0} : shift_nxt;

  // serial clock runs free at device clock over 8
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      sclk_r <= 1'b0;
    else if (half_ce)
      sclk_r <= !sclk_r;
  end

  // shared shift register; frames start only on the device's sample
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sp_st_r <= SP_IDLE;
      shreg_r <= '0;
      bit_cnt_r <= '0;
      pend_r <= 1'b0;
      rx_en_r <= 1'b0;
      sdo_o <= 1'b0;
      sdofs_o <= 1'b0;
    end
    else
    begin
      if (smp)
        pend_r <= 1'b1;
      case (sp_st_r)
        SP_IDLE:
        begin
          if (rise_ev && pend_r)
          begin
            pend_r <= smp;
            shreg_r <= tx_word;
            sdofs_o <= 1'b1;
            rx_en_r <= 1'b0;
            sp_st_r <= SP_SYNC;
          end
        end
        SP_SYNC:
        begin
          // host frame sync sits one bit ahead of its msb
          if (fall_ev && fs_s2_r)
            rx_en_r <= 1'b1;
          if (rise_ev)
          begin
            sdofs_o <= 1'b0;
            sdo_o <= shreg_r[15];
            bit_cnt_r <= '0;
            sp_st_r <= SP_SHIFT;
          end
        end
        SP_SHIFT:
        begin
          if (rise_ev)
            sdo_o <= shreg_r[15];
          if (fall_ev)
          begin
            shreg_r <= shift_nxt;
            bit_cnt_r <= bit_cnt_r + 5'h1;
            if (bit_cnt_r == SP_BITS_LAST)
              sp_st_r <= SP_IDLE;
          end
        end
        default:
          sp_st_r <= SP_IDLE;
      endcase
    end
  end

  // received words; a missing host word leaves the old dac word standing
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      dac_hold_r <= RST_DAC_WORD;
      ctl_word_r <= '0;
      dac_cur_r <= RST_DAC_WORD;
    end
    else
    begin
      if (frame_end && rx_en_r)
      begin
        if (is_ctrl)
          ctl_word_r <= shift_nxt;
        else
          dac_hold_r <= rx_dac;
      end
      if (smp)
        dac_cur_r <= dac_hold_r;
    end
  end

  // interpolator combs at the sample rate on the two's complement word
  assign e1 = INT_W'(signed'(dac_cur_r)) - ci_d1_r;
  assign e2 = e1 - ci_d2_r;
  assign e3 = e2 - ci_d3_r;
  // zero stuffing: the comb output enters once per sample interval
  assign ip_in = stuff_r ? comb_r : '0;
  // gain of n squared removed by shift
  assign ip_scaled = ig3_r >>> (2 * csf_log2n(rate_r));
  assign ip_out = (ip_scaled > INT_W'(signed'(DAC_POS_FS))) ? DAC_POS_FS
    : (ip_scaled < -INT_W'(signed'({1'b0, DAC_NEG_FS}))) ? DAC_NEG_FS
    : ip_scaled[15:0];
  assign dsm_in = byp_r ? dac_cur_r : ip_out;

  // comb state and one-tick stuffing flag
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ci_d1_r <= '0;
      ci_d2_r <= '0;
      ci_d3_r <= '0;
      comb_r <= '0;
      stuff_r <= 1'b0;
    end
    else
    begin
      if (smp)
      begin
        ci_d1_r <= INT_W'(signed'(dac_cur_r));
        ci_d2_r <= e1;
        ci_d3_r <= e2;
        comb_r <= e3;
      end
      if (smp)
        stuff_r <= 1'b1;
      else if (mod_ce)
        stuff_r <= 1'b0;
    end
  end

  // integrators at device clock over 8
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ig1_r <= '0;
      ig2_r <= '0;
      ig3_r <= '0;
    end
    else if (mod_ce)
    begin
      ig1_r <= ig1_r + ip_in;
      ig2_r <= ig2_r + ig1_r;
      ig3_r <= ig3_r + ig2_r;
    end
  end

  // first-order digital modulator; feedback is +/- full scale
  assign dsm_fb = dsm_acc_r[DSM_W-1] ? DSM_W'(signed'(DAC_NEG_FS))
    : DSM_W'(signed'(DAC_POS_FS));
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      dsm_acc_r <= '0;
      dac_bit_o <= 1'b0;
      mod_tick_o <= 1'b0;
    end
    else
    begin
      mod_tick_o <= mod_ce;
      if (mod_ce)
      begin
        dsm_acc_r <= dsm_acc_r + DSM_W'(signed'(dsm_in)) - dsm_fb;
        dac_bit_o <= !dsm_acc_r[DSM_W-1];
      end
    end
  end

  // bus decode; a write lands on the edge where the master sees ack
  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wb_wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
  assign lane0 = wb_sel_i[0];
  assign hit_mode = (wb_adr_i == OFS_PORT_MODE);
  assign hit_rate = (wb_adr_i == OFS_RATE_CTRL);
  assign hit_ref = (wb_adr_i == OFS_REF_CTRL);
  assign hit_gain = (wb_adr_i == OFS_GAIN_CTRL);
  assign hit_dac = (wb_adr_i == OFS_DAC_CTRL);
  assign hit_adc = (wb_adr_i == OFS_ADC_STAT);
  assign hit_word = (wb_adr_i == OFS_WORD_STAT);
  // unmapped addresses read as zero and still acknowledge
  assign rd_mux =
      hit_mode ? {30'h0, mode_r}
    : hit_rate ? {25'h0, mdiv_r, 2'h0, rate_r}
    : hit_ref ? {25'h0, ref_up_r, 6'h0}
    : hit_gain ? {24'h0, mute_r, gain_r, 4'h0}
    : hit_dac ? {26'h0, byp_r, 5'h0}
    : hit_adc ? {17'h0, adc_word}
    : hit_word ? {ctl_word_r, dac_hold_r}
    : 32'h0;

  // one wait state: ack the cycle after the request, drop it next
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end
    else
    begin
      wb_ack_o <= wb_req;
      if (wb_req)
        wb_dat_o <= rd_mux;
    end
  end

  // register writes, byte lane 0 holds every field
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      mode_r <= RST_MODE;
      rate_r <= RST_RATE_SEL;
      mdiv_r <= RST_MCLK_DIV;
      ref_up_r <= 1'b0;
      gain_r <= RST_GAIN_SEL;
      mute_r <= 1'b0;
      byp_r <= 1'b0;
    end
    else if (wb_wr && lane0)
    begin
      if (hit_mode)
        mode_r <= wb_dat_i[POS_MODE_MIXED:POS_MODE_DATA];
      if (hit_rate)
      begin
        rate_r <= wb_dat_i[POS_RATE_SEL+:2];
        mdiv_r <= wb_dat_i[POS_MCLK_DIV+:3];
      end
      if (hit_ref)
        ref_up_r <= wb_dat_i[POS_REF_UP];
      if (hit_gain)
      begin
        gain_r <= wb_dat_i[POS_GAIN_SEL+:3];
        mute_r <= wb_dat_i[POS_MUTE];
      end
      if (hit_dac)
        byp_r <= wb_dat_i[POS_IBYPASS];
    end
  end

  // analog controls straight from their registers
  assign output_gain_sel_o = gain_r;
  assign mute_o = mute_r;
  assign reference_output_enable_o = ref_up_r;
  assign sclk_o = sclk_r;
endmodule
`default_nettype wire

// ### test/csf_checker.sv
`timescale 1ns/1ps
`default_nettype none
module csf_checker (
  input wire logic clk_i, // clock
  input wire logic rst_i, // reset
  input wire logic wb_cyc_i, // cycle
  input wire logic wb_stb_i, // strobe
  input wire logic wb_we_i, // write
  input wire logic wb_ack_o, // ack
  input wire logic mod_tick_o, // tick
  input wire logic dac_bit_o, // dac bit
  input wire logic [2:0] output_gain_sel_o, // gain
  input wire logic mute_o, // mute
  input wire logic reference_output_enable_o, // ref enable
  input wire logic sclk_o, // serial clock
  input wire logic sdofs_o // frame sync
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // control outputs move only once a write was acknowledged
  sequence wr_landed_s;
    $past(wb_ack_o & wb_we_i);
  endsequence
  // sync bit lasts a whole serial period, 8 clocks or more
  sequence sync_bit_s;
    sdofs_o[*8];
  endsequence
  ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
    |=> wb_ack_o) else $error("no ack after request");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  tick_gap_a: assert property (
    mod_tick_o |=> (!mod_tick_o)[*7]) else $error("ticks too close");
  dac_step_a: assert property (
    $changed(dac_bit_o) |-> mod_tick_o) else $error("dac bit off tick");
  gain_write_a: assert property (
    $changed(output_gain_sel_o) |-> wr_landed_s) else $error("gain moved");
  mute_write_a: assert property (
    $changed(mute_o) |-> wr_landed_s) else $error("mute moved");
  ref_write_a: assert property (
    $changed(reference_output_enable_o) |-> wr_landed_s)
    else $error("reference enable moved");
  sync_width_a: assert property (
    $rose(sdofs_o) |-> sync_bit_s) else $error("sync bit too short");
  sclk_period_a: assert property (
    $rose(sclk_o) |=> (!$rose(sclk_o))[*7]) else $error("sclk too fast");
endmodule
bind csf_codec_core csf_checker chk_u (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
  .wb_we_i, .wb_ack_o, .mod_tick_o, .dac_bit_o, .output_gain_sel_o, .mute_o,
  .reference_output_enable_o, .sclk_o, .sdofs_o);
`default_nettype wire

// ### test/csf_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module csf_host_model (
  input wire logic clk_i, // bench clock
  input wire logic rst_i, // bench reset
  input wire logic sclk_i, // device serial clock
  input wire logic sdo_i, // device data
  input wire logic sdofs_i, // device frame sync
  input wire logic tx_en_i, // answer frames
  input wire logic [15:0] tx_word_i, // word to send
  output logic sdi_o, // data to device
  output logic sdifs_o, // sync to device
  output logic [15:0] rx_word_o, // last word taken
  output logic [15:0] frames_o // frames taken
);
  logic sclk_q, busy;
  logic [4:0] ntx, nrx;
  logic [15:0] rx_sh;
  wire logic rise = sclk_i & ~sclk_q;
  wire logic fall = ~sclk_i & sclk_q;
  // sdi changes at rises, far from the device's sampling falls
  always @(posedge clk_i)
  begin
    sclk_q <= sclk_i;
    // sync loops back from the device, so the host never opens a frame
    sdifs_o <= sdofs_i & tx_en_i & ~rst_i;
    if (rst_i)
    begin
      busy <= 1'b0;
      frames_o <= 16'h0000;
      rx_word_o <= 16'h0000;
      sdi_o <= 1'b0;
    end
    else
    begin
      if (rise && busy && ntx < 5'd16)
      begin
        sdi_o <= tx_word_i[4'(5'd15 - ntx)];
        ntx <= ntx + 5'd1;
      end
      else if (rise)
        sdi_o <= ~sdi_o; // idle line keeps toggling
      if (fall && busy)
      begin
        rx_sh <= {rx_sh[14:0], sdo_i};
        nrx <= nrx + 5'd1;
        busy <= (nrx != 5'd15);
        if (nrx == 5'd15)
        begin
          rx_word_o <= {rx_sh[14:0], sdo_i};
          frames_o <= frames_o + 16'h0001;
        end
      end
      else if (fall && sdofs_i)
      begin
        busy <= 1'b1;
        ntx <= 5'd0;
        nrx <= 5'd0;
      end
    end
  end
endmodule
`default_nettype wire

// ### test/tb_csf_codec_core.sv
`timescale 1ns/1ps
`default_nettype none
module tb_csf_codec_core;
  import csf_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h0;
  logic adc_bit_i = 1'b0;
  logic [3:0] sel = 4'hf;
  logic tx_en = 1'b0;
  logic [15:0] tx_word = 16'h0000;
  logic [31:0] wb_dat_o, rd;
  logic wb_ack_o, mod_tick_o, dac_bit_o, mute_o, reference_output_enable_o;
  logic sclk_o, sdo_o, sdofs_o, sdi_i, sdifs_i;
  logic [2:0] output_gain_sel_o;
  logic [15:0] rx_word, frames;
  int n_errors = 0;
  int n_compared = 0;
  int cyc = 0;
  int t0;
  // rate control values and the sample interval they give, in clocks
  logic [7:0] rate_tab [7] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h13, 8'h43,
    8'h53};
  int gap_tab [7] = '{2048, 1024, 512, 256, 512, 1280, 256};

  initial forever #4 clk_i = ~clk_i;
  always @(posedge clk_i) cyc <= cyc + 1;

  csf_codec_core dut_u (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .adc_bit_i,
    .mod_tick_o, .dac_bit_o, .output_gain_sel_o, .mute_o,
    .reference_output_enable_o, .sclk_o, .sdo_o, .sdofs_o, .sdi_i, .sdifs_i);
  csf_host_model host_u (.clk_i, .rst_i, .sclk_i(sclk_o), .sdo_i(sdo_o),
    .sdofs_i(sdofs_o), .tx_en_i(tx_en), .tx_word_i(tx_word), .sdi_o(sdi_i),
    .sdifs_o(sdifs_i), .rx_word_o(rx_word), .frames_o(frames));

  task automatic check(input string what, input logic [31:0] seen,
    input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one classic cycle, held until ack; returns an edge later, write visible
  task automatic wb_io(input logic we, input logic [7:0] adr,
    input logic [31:0] dat);
    int t;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    wb_sel_i <= sel;
    @(posedge clk_i);
    for (t = 0; wb_ack_o !== 1'b1 && t < 64; t++) @(posedge clk_i);
    if (t == 64) n_errors++;
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wait_frames(input int n);
    logic [15:0] f0;
    int t;
    f0 = frames;
    for (t = 0; 16'(frames - f0) < n && t < 3000 * n; t++) @(posedge clk_i);
  endtask

  // share of ones over 256 ticks; loose bounds allow filter settling
  task automatic density(input logic [15:0] w, input logic byp);
    int ones;
    tx_word <= w;
    wb_io(1'b1, OFS_DAC_CTRL, 32'(byp) << POS_IBYPASS);
    wait_frames(6);
    ones = 0;
    repeat (256)
    begin
      @(posedge clk_i);
      while (mod_tick_o !== 1'b1) @(posedge clk_i);
      ones += dac_bit_o;
    end
    check("dac density", 32'(w[15] ? ones <= 16 : ones >= 240), 1);
  endtask

  task automatic test_done;
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial
  begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    // all registers clear, unmapped 1c reads zero
    for (int a = 0; a < 8; a++)
    begin
      wb_io(1'b0, 8'(a * 4), 32'h0);
      check("reset read", rd, 32'h0);
    end
    $display("test reset values done");
    for (int g = 0; g < 16; g++)
    begin
      wb_io(1'b1, OFS_GAIN_CTRL, 32'(g) << POS_GAIN_SEL);
      check("gain", {29'h0, output_gain_sel_o}, 32'(g[2:0]));
      check("mute", {31'h0, mute_o}, 32'(g[3]));
    end
    sel = 4'he;
    wb_io(1'b1, OFS_GAIN_CTRL, 32'h0);
    sel = 4'hf;
    check("gain kept", {29'h0, output_gain_sel_o}, 32'h7);
    wb_io(1'b1, OFS_REF_CTRL, 32'h1 << POS_REF_UP);
    check("ref on", {31'h0, reference_output_enable_o}, 32'h1);
    wb_io(1'b1, OFS_REF_CTRL, 32'h0);
    check("ref off", {31'h0, reference_output_enable_o}, 32'h0);
    $display("test control bits done");
    adc_bit_i <= 1'b1;
    wb_io(1'b1, OFS_PORT_MODE, 32'h1);
    for (int i = 0; i < 7; i++)
    begin
      wb_io(1'b1, OFS_RATE_CTRL, {24'h0, rate_tab[i]});
      wait_frames(5);
      t0 = cyc;
      wait_frames(1);
      check("interval", 32'(cyc - t0), 32'(gap_tab[i]));
      wb_io(1'b0, OFS_ADC_STAT, 32'h0);
      check("adc word", rd, {17'h0, ADC_POS_MAX});
      check("tx word", {16'h0, rx_word},
        {16'h0, ADC_POS_MAX, 1'b0});
    end
    $display("test sample rates done");
    adc_bit_i <= 1'b0;
    wb_io(1'b1, OFS_PORT_MODE, 32'h3);
    wait_frames(5);
    wb_io(1'b0, OFS_ADC_STAT, 32'h0);
    check("adc word", rd, {17'h0, ADC_NEG_MAX});
    check("tx word", {16'h0, rx_word},
      {16'h0, FLAG_DATA, ADC_NEG_MAX});
    wb_io(1'b1, OFS_PORT_MODE, 32'h1);
    tx_word <= DAC_NEG_FS;
    tx_en <= 1'b1;
    wait_frames(3);
    wb_io(1'b0, OFS_WORD_STAT, 32'h0);
    check("dac word", {16'h0, rd[15:0]}, {16'h0, DAC_NEG_FS});
    tx_en <= 1'b0;
    wait_frames(3);
    wb_io(1'b0, OFS_WORD_STAT, 32'h0);
    check("dac word kept", {16'h0, rd[15:0]}, {16'h0, DAC_NEG_FS});
    wb_io(1'b1, OFS_PORT_MODE, 32'h3);
    tx_word <= 16'h8123;
    tx_en <= 1'b1;
    wait_frames(3);
    wb_io(1'b0, OFS_WORD_STAT, 32'h0);
    check("ctrl word", rd, {16'h8123, DAC_NEG_FS});
    tx_word <= 16'h1234;
    wait_frames(3);
    wb_io(1'b0, OFS_WORD_STAT, 32'h0);
    check("mixed dac word", rd, 32'h81232468);
    $display("test host words done");
    wb_io(1'b1, OFS_PORT_MODE, 32'h1);
    for (int b = 0; b < 2; b++)
    begin
      density(DAC_POS_FS, b[0]);
      density(DAC_NEG_FS, b[0]);
    end
    $display("test dac modulator done");
    test_done;
  end

  // cut a hang short well beyond the expected run length
  initial
  begin
    repeat (100000) @(posedge clk_i);
    n_errors++;
    test_done;
  end
endmodule
`default_nettype wire
